// ==== hdl/sgc_global_ctrl.sv ====
`timescale 1ns/100ps
// How it works
// - stop bit gates module clock, enters low power
// - while stopped only config reads valid
// - writes still stored while stopped
// - stop set by reset and CPU write
// - two-bit freeze field selects freeze reaction
// - freeze high bit halts at transfer boundary
// - freeze low bit has no effect
// - unimplemented bits ignore writes, read zero
// - level and vector bytes share word
// - address top bit from module-map select
// - one vector base, two request levels
module sgc_global_ctrl (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sgc_pkg::ADDR_W-1:0] paddr,
  input wire logic [sgc_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [sgc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic moduleMapSelect,
  input wire logic busFreeze,
  input wire logic xferBoundary,
  output logic moduleClkEn,
  output logic queuedHalt,
  output logic asyncRxEnable,
  output logic asyncTxEnable,
  output sgc_pkg::sgc_irq_cfg_t irqCfg
);

  // ==========================================================
  // request decode
  sgc_pkg::sgc_apb_req_t req;
  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr,
                 wdata: pwdata, strb: pstrb};

  logic [sgc_pkg::REG_W-1:0] cfg_q;
  logic [sgc_pkg::REG_W-1:0] intr_q;
  logic [sgc_pkg::REG_W-1:0] qctl3_q;
  logic [sgc_pkg::REG_W-1:0] async_q;
  logic [sgc_pkg::REG_W-1:0] ram [sgc_pkg::RAM_DEPTH];
  sgc_pkg::sgc_qstate_t qState_q;
  logic [sgc_pkg::DATA_W-1:0] prdata_q;
  logic [sgc_pkg::DATA_W-1:0] rdata_d;
  logic pready_q;
  logic pslverr_q;
  logic clkEn_q;
  logic qHalt_q;
  logic rxEn_q;
  logic txEn_q;
  sgc_pkg::sgc_irq_cfg_t irq_q;

  logic inModule;
  logic [sgc_pkg::OFS_HI:0] ofs;
  logic isRam;
  logic [sgc_pkg::RAM_IDX_W-1:0] ramIdx;
  logic mapped;
  logic wrDone;
  logic stopped;
  logic haltWanted;

  // merge the two low byte lanes of the bus into a 16-bit register
  function automatic logic [sgc_pkg::REG_W-1:0] laneMerge(
    input logic [sgc_pkg::REG_W-1:0] old,
    input logic [sgc_pkg::DATA_W-1:0] wd,
    input logic [3:0] be,
    input logic [sgc_pkg::REG_W-1:0] mask
  );
    logic [sgc_pkg::REG_W-1:0] nv;
    nv = old;
    if (be[0]) begin
      nv[7:0] = wd[7:0];
    end
    if (be[1]) begin
      nv[15:8] = wd[15:8];
    end
    laneMerge = (nv & mask) | (old & ~mask);
  endfunction

  function automatic logic ofsIs(
    input logic [sgc_pkg::OFS_HI:0] a,
    input logic [sgc_pkg::OFS_HI:0] b
  );
    ofsIs = (a == b);
  endfunction

  // the module window moves with the map select bit
  assign inModule = (req.addr[sgc_pkg::MAP_BIT] == moduleMapSelect) &&
                    (req.addr[sgc_pkg::BASE_HI:sgc_pkg::BASE_LO] == sgc_pkg::MODULE_BASE);
  assign ofs = req.addr[sgc_pkg::OFS_HI:0];
  assign isRam = ofs[sgc_pkg::OFS_HI];
  assign ramIdx = ofs[sgc_pkg::RAM_IDX_LO +: sgc_pkg::RAM_IDX_W];
  assign mapped = inModule && (isRam || ofsIs(ofs, sgc_pkg::OFS_CONFIG) ||
                  ofsIs(ofs, sgc_pkg::OFS_TEST) || ofsIs(ofs, sgc_pkg::OFS_INTR) ||
                  ofsIs(ofs, sgc_pkg::OFS_QCTL3) || ofsIs(ofs, sgc_pkg::OFS_ASYNC));
  // writes land only at the edge where the master sees pready
  assign wrDone = req.sel && req.enable && pready_q && req.write && mapped;
  assign stopped = cfg_q[sgc_pkg::CFG_STOP];

  // ==========================================================
  // config register: stop, freeze field, arbitration id
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_q <= sgc_pkg::CFG_RESET;
    end else if (wrDone && !isRam && ofsIs(ofs, sgc_pkg::OFS_CONFIG)) begin
      // freeze low bit is stored and read back, but no logic uses it
      cfg_q <= laneMerge(cfg_q, req.wdata, req.strb, sgc_pkg::CFG_MASK);
    end
  end

  // ==========================================================
  // interrupt level byte and vector byte in one word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      intr_q <= sgc_pkg::INTR_RESET;
    end else if (wrDone && !isRam && ofsIs(ofs, sgc_pkg::OFS_INTR)) begin
      // vector bit 0 is supplied per source, so writes to it are dropped
      intr_q <= laneMerge(intr_q, req.wdata, req.strb, sgc_pkg::INTR_MASK);
    end
  end

  // ==========================================================
  // port controls; accepted even while stopped
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      qctl3_q <= sgc_pkg::ZERO16;
    end else if (wrDone && !isRam && ofsIs(ofs, sgc_pkg::OFS_QCTL3)) begin
      qctl3_q <= laneMerge(qctl3_q, req.wdata, req.strb, sgc_pkg::Q3_MASK);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      async_q <= sgc_pkg::ZERO16;
    end else if (wrDone && !isRam && ofsIs(ofs, sgc_pkg::OFS_ASYNC)) begin
      async_q <= laneMerge(async_q, req.wdata, req.strb, sgc_pkg::AS_MASK);
    end
  end

  // ==========================================================
  // queue RAM: writes always land, reads blocked while stopped
  always_ff @(posedge mclk) begin
    if (wrDone && isRam) begin
      ram[ramIdx] <= laneMerge(ram[ramIdx], req.wdata, req.strb, 16'hFFFF);
    end
  end

  // ==========================================================
  // queued port halt sequencing
  assign haltWanted = qctl3_q[sgc_pkg::Q3_HALT] ||
                      (cfg_q[sgc_pkg::CFG_FRZ_HI] && busFreeze);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      qState_q <= sgc_pkg::Q_RUN;
    end else begin
      unique case (qState_q)
        sgc_pkg::Q_RUN: begin
          if (haltWanted) begin
            qState_q <= sgc_pkg::Q_DRAIN;
          end
        end
        sgc_pkg::Q_DRAIN: begin
          // the transfer in flight is allowed to finish
          if (!haltWanted) begin
            qState_q <= sgc_pkg::Q_RUN;
          end else if (xferBoundary) begin
            qState_q <= sgc_pkg::Q_HALTED;
          end
        end
        sgc_pkg::Q_HALTED: begin
          if (!haltWanted) begin
            qState_q <= sgc_pkg::Q_RUN;
          end
        end
        default: begin
          qState_q <= sgc_pkg::Q_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs to the sub-units, all registered
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clkEn_q <= 1'b0;
    end else begin
      // registers sit outside the gated domain, so resuming loses nothing
      clkEn_q <= !stopped;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      qHalt_q <= 1'b0;
      rxEn_q <= 1'b0;
      txEn_q <= 1'b0;
    end else begin
      qHalt_q <= (qState_q != sgc_pkg::Q_RUN);
      rxEn_q <= async_q[sgc_pkg::AS_RXEN];
      txEn_q <= async_q[sgc_pkg::AS_TXEN];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_q <= '0;
    end else begin
      irq_q.levelQueued <= intr_q[sgc_pkg::LVL_Q_HI:sgc_pkg::LVL_Q_LO];
      irq_q.levelAsync <= intr_q[sgc_pkg::LVL_A_HI:sgc_pkg::LVL_A_LO];
      irq_q.vectorHigh <= intr_q[7:1];
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    rdata_d = '0;
    if (isRam) begin
      // limitation: queue RAM is unreadable while stopped, returns zero
      if (!stopped) begin
        rdata_d[sgc_pkg::REG_W-1:0] = ram[ramIdx];
      end
    end else if (ofsIs(ofs, sgc_pkg::OFS_CONFIG)) begin
      rdata_d[sgc_pkg::REG_W-1:0] = cfg_q & sgc_pkg::CFG_MASK;
    end else if (!stopped) begin
      if (ofsIs(ofs, sgc_pkg::OFS_INTR)) begin
        rdata_d[sgc_pkg::REG_W-1:0] = intr_q | sgc_pkg::VEC_LOW_ONE;
      end else if (ofsIs(ofs, sgc_pkg::OFS_QCTL3)) begin
        rdata_d[sgc_pkg::REG_W-1:0] = qctl3_q & sgc_pkg::Q3_MASK;
        rdata_d[sgc_pkg::Q3_HALTACK] = (qState_q == sgc_pkg::Q_HALTED);
      end else if (ofsIs(ofs, sgc_pkg::OFS_ASYNC)) begin
        rdata_d[sgc_pkg::REG_W-1:0] = async_q & sgc_pkg::AS_MASK;
      end
    end
  end

  // ==========================================================
  // APB answer: one wait state, then pready for one cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (req.sel && req.enable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      // stopped reads other than config are not guaranteed; they answer zero
      prdata_q <= (mapped && !req.write) ? rdata_d : '0;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign moduleClkEn = clkEn_q;
  assign queuedHalt = qHalt_q;
  assign asyncRxEnable = rxEn_q;
  assign asyncTxEnable = txEn_q;
  assign irqCfg = irq_q;

endmodule

// ==== hdl/sgc_pkg.sv ====
package sgc_pkg;

  // ==========================================================
  // bus shape
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // ==========================================================
  // decode: bit 23 follows the module-map select, bits 22:9 pick the module
  localparam int MAP_BIT = 23;
  localparam int BASE_HI = 22;
  localparam int BASE_LO = 9;
  localparam logic [13:0] MODULE_BASE = 14'h3E00;
  localparam int OFS_HI = 8;

  // ==========================================================
  // register byte offsets inside the module window
  localparam logic [8:0] OFS_CONFIG = 9'h000;
  localparam logic [8:0] OFS_TEST = 9'h004;
  localparam logic [8:0] OFS_INTR = 9'h008;
  localparam logic [8:0] OFS_QCTL3 = 9'h00C;
  localparam logic [8:0] OFS_ASYNC = 9'h010;
  localparam logic [8:0] OFS_RAM = 9'h100;
  localparam int RAM_DEPTH = 16;
  localparam int RAM_IDX_W = 4;
  localparam int RAM_IDX_LO = 2;

  // ==========================================================
  // config register fields
  localparam int CFG_STOP = 15;
  localparam int CFG_FRZ_HI = 14;
  localparam int CFG_FRZ_LO = 13;
  localparam int CFG_ARB_HI = 3;
  localparam int CFG_ARB_LO = 0;
  localparam logic [REG_W-1:0] CFG_MASK = 16'hE00F;
  localparam logic [REG_W-1:0] CFG_RESET = 16'h8000;

  // ==========================================================
  // interrupt word: level byte high, vector byte low
  localparam int LVL_Q_HI = 13;
  localparam int LVL_Q_LO = 11;
  localparam int LVL_A_HI = 10;
  localparam int LVL_A_LO = 8;
  localparam logic [REG_W-1:0] INTR_MASK = 16'h3FFE;
  localparam logic [REG_W-1:0] INTR_RESET = 16'h000F;
  localparam logic [REG_W-1:0] VEC_LOW_ONE = 16'h0001;

  // ==========================================================
  // queued port control three and async port control
  localparam int Q3_HALT = 0;
  localparam int Q3_HALTACK = 1;
  localparam logic [REG_W-1:0] Q3_MASK = 16'h0001;
  localparam int AS_RXEN = 0;
  localparam int AS_TXEN = 1;
  localparam logic [REG_W-1:0] AS_MASK = 16'h0003;
  localparam logic [REG_W-1:0] ZERO16 = 16'h0000;

  typedef enum logic [1:0] {
    Q_RUN,
    Q_DRAIN,
    Q_HALTED
  } sgc_qstate_t;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] strb;
  } sgc_apb_req_t;

  typedef struct packed {
    logic [2:0] levelQueued;
    logic [2:0] levelAsync;
    logic [7:1] vectorHigh;
  } sgc_irq_cfg_t;

endpackage

// ==== tb/sgc_global_ctrl_asserts.sv ====
`timescale 1ns/100ps
module sgc_global_ctrl_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sgc_pkg::ADDR_W-1:0] paddr,
  input wire logic [sgc_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [sgc_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic moduleMapSelect,
  input wire logic moduleClkEn
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic acc;
  logic cfgWr;
  assign acc = psel && penable && !pready;
  assign cfgWr = psel && penable && pready && pwrite && pstrb[1]
    && paddr[23] == moduleMapSelect && paddr[22:9] == sgc_pkg::MODULE_BASE
    && paddr[8:0] == sgc_pkg::OFS_CONFIG;
  property p_answer; acc |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held two cycles");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_hi; pready |-> prdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_inacc; pready |-> psel && penable; endproperty
  a_inacc: assert property (p_inacc) else $error("ready outside access");
  property p_map; acc && paddr[23] != moduleMapSelect |=> pslverr; endproperty
  a_map: assert property (p_map) else $error("wrong map bit accepted");
  property p_rst; $fell(sys_rst) |-> !moduleClkEn; endproperty
  a_rst: assert property (p_rst) else $error("clock on after reset");
  property p_stop; cfgWr |-> ##2 moduleClkEn == !$past(pwdata[15], 2); endproperty
  a_stop: assert property (p_stop) else $error("clock enable not stop");
endmodule
bind sgc_global_ctrl sgc_global_ctrl_chk u_chk (.mclk, .sys_rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .moduleMapSelect, .moduleClkEn);

// ==== tb/sgc_qport_model.sv ====
`timescale 1ns/100ps
// queued port stand-in: a transfer ends every 8 cycles, halted or not
module sgc_qport_model (
  input wire logic mclk,
  input wire logic sys_rst,
  output logic xferBoundary
);
  logic [2:0] cnt_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) cnt_q <= 3'h0;
    else cnt_q <= cnt_q + 3'h1;
  end
  assign xferBoundary = cnt_q == 3'h7;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, mms, busFreeze, xferBoundary;
  logic moduleClkEn, queuedHalt, asyncRxEnable, asyncTxEnable, aHi, err;
  logic [23:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  sgc_pkg::sgc_irq_cfg_t irqCfg;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  sgc_global_ctrl dut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .moduleMapSelect(mms), .busFreeze, .xferBoundary,
    .moduleClkEn, .queuedHalt, .asyncRxEnable, .asyncTxEnable, .irqCfg);
  sgc_qport_model qport (.mclk, .sys_rst, .xferBoundary);
  always #10 mclk = ~mclk;
  // ==========================================================
  // shared tasks
  task automatic wrap_up;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [8:0] o, input logic [15:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {aHi, sgc_pkg::MODULE_BASE, o};
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    cmp("clk_en", 32'h0, {31'h0, moduleClkEn});
    apb(1'b0, sgc_pkg::OFS_CONFIG, 16'h0000);
    cmp("config", 32'h8000, rd);
    cmp("irq_cfg", 32'h0007, {19'h0, irqCfg});
  endtask
  task automatic t_stopped;
    apb(1'b1, sgc_pkg::OFS_RAM, 16'hA5C3);
    apb(1'b1, sgc_pkg::OFS_INTR, 16'h2D44);
    apb(1'b1, sgc_pkg::OFS_ASYNC, 16'h0003);
    apb(1'b0, sgc_pkg::OFS_INTR, 16'h0000);
    cmp("stopped_read", 32'h0, rd);
    apb(1'b0, sgc_pkg::OFS_CONFIG, 16'h0000);
    cmp("stopped_cfg", 32'h8000, rd);
    apb(1'b1, sgc_pkg::OFS_CONFIG, 16'h0000);
    repeat (2) @(posedge mclk);
    cmp("clk_en", 32'h1, {31'h0, moduleClkEn});
    apb(1'b0, sgc_pkg::OFS_RAM, 16'h0000);
    cmp("ram", 32'hA5C3, rd);
    apb(1'b0, sgc_pkg::OFS_INTR, 16'h0000);
    cmp("intr_word", 32'h2D45, rd);
    cmp("irq_cfg", {19'h0, 3'h5, 3'h5, 7'h22}, {19'h0, irqCfg});
    apb(1'b0, sgc_pkg::OFS_ASYNC, 16'h0000);
    cmp("async", 32'h3, rd);
    cmp("rx_tx", 32'h3, {30'h0, asyncTxEnable, asyncRxEnable});
  endtask
  task automatic t_bits;
    apb(1'b1, sgc_pkg::OFS_CONFIG, 16'h7FFF);
    apb(1'b0, sgc_pkg::OFS_CONFIG, 16'h0000);
    cmp("config", 32'h600F, rd);
    apb(1'b1, sgc_pkg::OFS_TEST, 16'hFFFF);
    apb(1'b0, sgc_pkg::OFS_TEST, 16'h0000);
    cmp("test", 32'h0, rd);
    apb(1'b1, sgc_pkg::OFS_INTR, 16'hFFFF);
    apb(1'b0, sgc_pkg::OFS_INTR, 16'h0000);
    cmp("intr_word", 32'h3FFF, rd);
  endtask
  task automatic t_map;
    aHi <= 1'b1;
    apb(1'b1, sgc_pkg::OFS_CONFIG, 16'h8000);
    cmp("err", 32'h1, {31'h0, err});
    mms <= 1'b1;
    apb(1'b0, sgc_pkg::OFS_CONFIG, 16'h0000);
    cmp("err", 32'h0, {31'h0, err});
    cmp("config", 32'h600F, rd);
    mms <= 1'b0;
    aHi <= 1'b0;
  endtask
  task automatic t_freeze;
    apb(1'b1, sgc_pkg::OFS_CONFIG, 16'h2000);
    busFreeze <= 1'b1;
    repeat (20) @(posedge mclk);
    cmp("halt_low", 32'h0, {31'h0, queuedHalt});
    apb(1'b1, sgc_pkg::OFS_CONFIG, 16'h4000);
    rd = 32'h0;
    for (int i = 0; i < 10 && rd[1] !== 1'b1; i++) apb(1'b0, sgc_pkg::OFS_QCTL3, 16'h0000);
    cmp("frz_ack", 32'h2, rd);
    cmp("halt_high", 32'h1, {31'h0, queuedHalt});
    busFreeze <= 1'b0;
    // software shutdown order: halt, wait for ack, idle async port, then stop
    apb(1'b1, sgc_pkg::OFS_QCTL3, 16'h0001);
    rd = 32'h0;
    for (int i = 0; i < 10 && rd[1] !== 1'b1; i++) apb(1'b0, sgc_pkg::OFS_QCTL3, 16'h0000);
    cmp("sw_ack", 32'h3, rd);
    apb(1'b1, sgc_pkg::OFS_ASYNC, 16'h0000);
    apb(1'b1, sgc_pkg::OFS_CONFIG, 16'h8000);
    repeat (2) @(posedge mclk);
    cmp("clk_en", 32'h0, {31'h0, moduleClkEn});
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up;
    end
  end
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 24'h0;
    pwdata = 32'h0;
    pstrb = 4'h3;
    mms = 1'b0;
    aHi = 1'b0;
    busFreeze = 1'b0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_stopped;
    t_bits;
    t_map;
    t_freeze;
    wrap_up;
  end
endmodule
